// *** dce_analog_model.sv ***
// Behavioural model of the two analog comparator outputs
`timescale 1ns/1ns
module dce_analog_model #(
	parameter int SETTLE = 7 // Settling time in ns, off the clock grid
) (
	input  wire logic wantFirst,     // Level the first comparator should reach
	input  wire logic wantSecond,    // Level the second comparator should reach
	output logic      firstCompRaw,  // Asynchronous first comparator output
	output logic      secondCompRaw  // Asynchronous second comparator output
);
	// Outputs follow their targets late and unrelated to the clock
	// Only comparator outputs are driven; the input pins stay floating inputs
	always @(wantFirst) firstCompRaw <= #SETTLE wantFirst;
	always @(wantSecond) secondCompRaw <= #SETTLE wantSecond;
endmodule

// *** dce_comparator_control.sv ***
// Register file, event flags and wake logic of the two comparators, and output routing of the second comparator
//
// Overview of operation
// - Comparators work in every low-power state; wake in all but halt with reference stopped
// - Request raised only when flag and enable set
// - No halt wake while reference stopped
// - ADC owns switches, at most one closed
// - Input selection writable after comparator enabled
// - Second output routable to four timer inputs
// - Second threshold selectable among eight codes
// - Fixed comparator input reached by switch bank
// - Polarity setting chooses output edge direction
// - Second comparator has speed setting
// - Edge field: off, fall, rise, both
// - Flag set on edge, cleared writing zero
// - Route field codes; pin path disconnected
// - Inverting input field has eight codes
`timescale 1ns/1ns
`include "dce_defines.svh"

module dce_comparator_control #(
	parameter int ADDR_WIDTH = 8 // AXI address width
) (
	input  wire logic                  clock,
	input  wire logic                  sys_rst,
	// AXI4-Lite slave
	input  wire logic [ADDR_WIDTH-1:0] awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [ADDR_WIDTH-1:0] araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	// Analog side
	input  wire logic                  firstCompRaw,         // Fixed comparator output
	input  wire logic                  secondCompRaw,        // Selectable comparator output
	input  wire logic                  ultraLowPower,        // Reference stopped in halt
	input  wire logic                  adcEnable,            // ADC owns the switches
	input  wire logic [3:0]            adcChannel,           // Switch the ADC closes
	input  wire logic                  pinCaptureFirst,      // Pin path to first capture 2
	input  wire logic                  pinCaptureSecond,     // Pin path to second capture 2
	input  wire logic                  pinBreak,             // Pin path to break input
	output logic                       irqRequest,           // Comparator interrupt
	output logic                       wakeFromWait,         // Exit wait states
	output logic                       wakeFromHalt,         // Exit halt states
	output logic                       referenceConnect,     // Reference to first inverting
	output logic                       windowEnable,         // Window mode
	output logic                       referenceOutEnable,   // Reference onto pins
	output logic                       schmittEnable,        // Pin Schmitt triggers
	output logic                       secondSpeedFast,      // Second comparator speed
	output logic [2:0]                 invertingInputSelect, // Second threshold mux
	output logic [5:0]                 inputTrigOff,         // Input pin trigger disables
	output logic [5:0]                 outputTrigOff,        // Output pin trigger disables
	output logic [14:0]                analogSwitch,         // Routing switches
	output logic                       firstCaptureTwo,      // First timer capture 2
	output logic                       secondCaptureTwo,     // Second timer capture 2
	output logic                       timerBreakInput,      // Advanced timer break
	output logic                       referenceClearInput   // Advanced timer ref clear
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Register index from a byte address
	function automatic logic [2:0] regIndex(input logic [ADDR_WIDTH-1:0] addr);
		return addr[4:2];
	endfunction
	// Address falls on a mapped register
	function automatic logic isMapped(input logic [ADDR_WIDTH-1:0] addr);
		return (addr >> 5) == '0 && addr[4:2] <= `DCE_IDX_LAST;
	endfunction

	// Reset image of the whole state
	function automatic dce_pkg::dce_ctrl_t resetState();
		dce_pkg::dce_ctrl_t r;
		r                   = '0;
		r.awReady           = 1'b1;
		r.wReady            = 1'b1;
		r.arReady           = 1'b1;
		r.outputRouteSelect = 2'(`DCE_ROUTE_RESET >> `DCE_ROUTE_LSB); // Route field of the reset image
		return r;
	endfunction
	localparam dce_pkg::dce_ctrl_t RESET_STATE = resetState();
	dce_pkg::dce_ctrl_t s;       // Current state
	dce_pkg::dce_ctrl_t next_s;  // Next state
	logic               firstLevel;   // Synchronised fixed comparator level
	logic               secondLevel;  // Synchronised selectable comparator level
	logic               firstEvent;   // Selected edge on fixed comparator
	logic               secondEvent;  // Selected edge on selectable comparator
	logic               doWrite;      // Register write happens this cycle
	logic               clearFirst;   // Write of zero to the first flag
	logic               clearSecond;  // Write of zero to the second flag
	// ----------------------------------------
	// Comparator edge detectors
	// ----------------------------------------
	dce_edge_detect firstEdge (
		.clock      (clock),
		.sys_rst    (sys_rst),
		.rawLevel   (firstCompRaw),
		.invert     (s.polarity[0]),
		.edgeSelect (s.firstEdgeSelect),
		.level      (firstLevel),
		.edgeEvent  (firstEvent)
	);
	dce_edge_detect secondEdge (
		.clock      (clock),
		.sys_rst    (sys_rst),
		.rawLevel   (secondCompRaw),
		.invert     (s.polarity[1]),
		.edgeSelect (s.secondEdgeSelect),
		.level      (secondLevel),
		.edgeEvent  (secondEvent)
	);
	// Register read image
	function automatic logic [31:0] readWord(input dce_pkg::dce_ctrl_t st, input logic [2:0] idx,
			input logic lvl1, input logic lvl2);
		logic [31:0] w;
		w = '0;
		unique case (idx)
			`DCE_IDX_FIRST_CTRL: begin
				w[`DCE_IRQ_EN_BIT]              = st.firstIrqEnable;
				w[`DCE_FLAG_BIT]                = st.firstEventFlag;
				w[`DCE_LEVEL_BIT]               = lvl1;
				w[`DCE_STE_BIT]                 = st.schmittEnable;
				w[`DCE_EDGE_MSB:`DCE_EDGE_LSB]  = st.firstEdgeSelect;
			end
			`DCE_IDX_SECOND_CTRL: begin
				w[`DCE_IRQ_EN_BIT]              = st.secondIrqEnable;
				w[`DCE_FLAG_BIT]                = st.secondEventFlag;
				w[`DCE_LEVEL_BIT]               = lvl2;
				w[`DCE_SPEED_BIT]               = st.secondSpeedFast;
				w[`DCE_EDGE_MSB:`DCE_EDGE_LSB]  = st.secondEdgeSelect;
			end
			`DCE_IDX_ROUTE_CTRL: begin
				w[`DCE_ROUTE_MSB:`DCE_ROUTE_LSB] = st.outputRouteSelect;
				w[`DCE_INSEL_MSB:`DCE_INSEL_LSB] = st.invertingInputSelect;
				w[`DCE_REFCON_BIT]               = st.referenceConnect;
				w[`DCE_WINDOW_BIT]               = st.windowEnable;
				w[`DCE_REFOUT_BIT]               = st.referenceOutEnable;
			end
			`DCE_IDX_TRIG_A:   w[`DCE_TRIG_MSB:0] = st.inputTrigOff;
			`DCE_IDX_TRIG_B:   w[`DCE_TRIG_MSB:0] = st.outputTrigOff;
			`DCE_IDX_SWITCH:   w[`DCE_SWITCH_COUNT-1:0] = st.analogSwitchSet;
			`DCE_IDX_POLARITY: w[1:0] = st.polarity;
			default:           w = '0;
		endcase
		return w;
	endfunction

	// ----------------------------------------
	// Flag clear decode
	// ----------------------------------------
	// A write of zero to a flag clears it; a write of one leaves it
	assign doWrite     = s.wrState == dce_pkg::WR_COLLECT && !s.awReady && !s.wReady && s.awOk;
	assign clearFirst  = doWrite && s.awIdx == `DCE_IDX_FIRST_CTRL && s.wStrb[0]
		&& !s.wData[`DCE_FLAG_BIT];
	assign clearSecond = doWrite && s.awIdx == `DCE_IDX_SECOND_CTRL && s.wStrb[0]
		&& !s.wData[`DCE_FLAG_BIT];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		// Write channel: take address and data in either order, then answer
		unique case (s.wrState)
			dce_pkg::WR_COLLECT: begin
				if (awvalid && s.awReady) begin
					next_s.awReady = 1'b0;
					next_s.awIdx   = regIndex(awaddr);
					next_s.awOk    = isMapped(awaddr);
				end
				if (wvalid && s.wReady) begin
					next_s.wReady = 1'b0;
					next_s.wData  = wdata;
					next_s.wStrb  = wstrb;
				end
				if (!s.awReady && !s.wReady) begin
					next_s.bValid  = 1'b1;
					next_s.bResp   = s.awOk ? `DCE_RESP_OKAY : `DCE_RESP_SLVERR;
					next_s.wrState = dce_pkg::WR_RESPOND;
				end
			end
			dce_pkg::WR_RESPOND: begin
				if (bready) begin
					next_s.bValid  = 1'b0;
					next_s.awReady = 1'b1;
					next_s.wReady  = 1'b1;
					next_s.wrState = dce_pkg::WR_COLLECT;
				end
			end
		endcase

		// Register updates; every field stays writable while comparators run
		if (doWrite && s.wStrb[0]) begin
			unique case (s.awIdx)
				`DCE_IDX_FIRST_CTRL: begin
					next_s.firstIrqEnable  = s.wData[`DCE_IRQ_EN_BIT];
					next_s.schmittEnable   = s.wData[`DCE_STE_BIT];
					next_s.firstEdgeSelect = s.wData[`DCE_EDGE_MSB:`DCE_EDGE_LSB];
				end
				`DCE_IDX_SECOND_CTRL: begin
					next_s.secondIrqEnable  = s.wData[`DCE_IRQ_EN_BIT];
					next_s.secondSpeedFast  = s.wData[`DCE_SPEED_BIT];
					next_s.secondEdgeSelect = s.wData[`DCE_EDGE_MSB:`DCE_EDGE_LSB];
				end
				`DCE_IDX_ROUTE_CTRL: begin
					next_s.outputRouteSelect    = s.wData[`DCE_ROUTE_MSB:`DCE_ROUTE_LSB];
					next_s.invertingInputSelect = s.wData[`DCE_INSEL_MSB:`DCE_INSEL_LSB];
					next_s.referenceConnect     = s.wData[`DCE_REFCON_BIT];
					next_s.windowEnable         = s.wData[`DCE_WINDOW_BIT];
					next_s.referenceOutEnable   = s.wData[`DCE_REFOUT_BIT];
				end
				`DCE_IDX_TRIG_A:   next_s.inputTrigOff  = s.wData[`DCE_TRIG_MSB:0];
				`DCE_IDX_TRIG_B:   next_s.outputTrigOff = s.wData[`DCE_TRIG_MSB:0];
				`DCE_IDX_SWITCH:   next_s.analogSwitchSet[7:0] = s.wData[7:0];
				`DCE_IDX_POLARITY: next_s.polarity = s.wData[1:0];
				default: ;
			endcase
		end
		if (doWrite && s.wStrb[1] && s.awIdx == `DCE_IDX_SWITCH) begin
			next_s.analogSwitchSet[14:8] = s.wData[14:8];
		end
		// Sticky flags: an edge in the clearing cycle still sets the flag
		next_s.firstEventFlag  = (s.firstEventFlag & ~clearFirst) | firstEvent;
		next_s.secondEventFlag = (s.secondEventFlag & ~clearSecond) | secondEvent;
		// Read channel: one answer per address taken
		unique case (s.rdState)
			dce_pkg::RD_IDLE: begin
				if (arvalid && s.arReady) begin
					next_s.arReady = 1'b0;
					next_s.rValid  = 1'b1;
					next_s.rData   = isMapped(araddr)
						? readWord(s, regIndex(araddr), firstLevel, secondLevel) : '0;
					next_s.rResp   = isMapped(araddr) ? `DCE_RESP_OKAY : `DCE_RESP_SLVERR;
					next_s.rdState = dce_pkg::RD_RESPOND;
				end
			end
			dce_pkg::RD_RESPOND: begin
				if (rready) begin
					next_s.rValid  = 1'b0;
					next_s.arReady = 1'b1;
					next_s.rdState = dce_pkg::RD_IDLE;
				end
			end
		endcase

		// Interrupt and wake; no gating by power state, only by the reference
		next_s.irqRequest   = (s.firstEventFlag & s.firstIrqEnable)
			| (s.secondEventFlag & s.secondIrqEnable);
		next_s.wakeFromWait = next_s.irqRequest;
		next_s.wakeFromHalt = next_s.irqRequest & ~ultraLowPower;
		// ADC takes the switches over with at most one closed switch, none for a channel of 15
		if (adcEnable) begin
			next_s.analogSwitch = (adcChannel < 4'(`DCE_SWITCH_COUNT))
				? 15'h0001 << adcChannel : 15'h0000;
		end else begin
			next_s.analogSwitch = s.analogSwitchSet;
		end

		// Timer pin paths synchronised before use
		next_s.pinMeta = {pinBreak, pinCaptureSecond, pinCaptureFirst};
		next_s.pinSync = s.pinMeta;

		// Route the second comparator; the chosen pin path is disconnected
		next_s.firstCaptureTwo     = (s.outputRouteSelect == `DCE_ROUTE_CAP_FIRST)
			? secondLevel : s.pinSync[0];
		next_s.secondCaptureTwo    = (s.outputRouteSelect == `DCE_ROUTE_CAP_SECOND)
			? secondLevel : s.pinSync[1];
		next_s.timerBreakInput     = (s.outputRouteSelect == `DCE_ROUTE_BREAK)
			? secondLevel : s.pinSync[2];
		next_s.referenceClearInput = (s.outputRouteSelect == `DCE_ROUTE_REFCLR)
			& secondLevel;
	end

	// State register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s <= RESET_STATE;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_comb begin
		awready              = s.awReady;
		wready               = s.wReady;
		bvalid               = s.bValid;
		bresp                = s.bResp;
		arready              = s.arReady;
		rvalid               = s.rValid;
		rdata                = s.rData;
		rresp                = s.rResp;
		irqRequest           = s.irqRequest;
		wakeFromWait         = s.wakeFromWait;
		wakeFromHalt         = s.wakeFromHalt;
		referenceConnect     = s.referenceConnect;
		windowEnable         = s.windowEnable;
		referenceOutEnable   = s.referenceOutEnable;
		schmittEnable        = s.schmittEnable;
		secondSpeedFast      = s.secondSpeedFast;
		invertingInputSelect = s.invertingInputSelect;
		inputTrigOff         = s.inputTrigOff;
		outputTrigOff        = s.outputTrigOff;
		analogSwitch         = s.analogSwitch;
		firstCaptureTwo      = s.firstCaptureTwo;
		secondCaptureTwo     = s.secondCaptureTwo;
		timerBreakInput      = s.timerBreakInput;
		referenceClearInput  = s.referenceClearInput;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_flag_sets: assert property (firstEvent |=> s.firstEventFlag)
		else $error("first flag missed its edge");
	a_flag_sticky: assert property (s.secondEventFlag && !clearSecond |=> s.secondEventFlag)
		else $error("second flag dropped without a zero write");
	a_flag_clears: assert property (clearFirst && !firstEvent |=> !s.firstEventFlag)
		else $error("first flag not cleared by zero write");
	a_irq_gated: assert property (##1 irqRequest == $past((s.firstEventFlag && s.firstIrqEnable)
		|| (s.secondEventFlag && s.secondIrqEnable)))
		else $error("interrupt does not follow flag and enable");
	a_wait_wake: assert property (wakeFromWait == irqRequest)
		else $error("wait wake differs from interrupt");
	a_halt_blocked: assert property (ultraLowPower |=> !wakeFromHalt)
		else $error("halt wake with reference stopped");
	a_adc_onehot: assert property (adcEnable |=> $onehot0(analogSwitch))
		else $error("more than one switch closed under ADC");
	a_route_break: assert property ((s.outputRouteSelect == `DCE_ROUTE_BREAK)
		|=> timerBreakInput == $past(secondLevel))
		else $error("break input not driven by comparator");
	a_refclr_idle: assert property ((s.outputRouteSelect != `DCE_ROUTE_REFCLR)
		|=> !referenceClearInput)
		else $error("reference clear driven while not routed");
	a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read not answered next cycle");

	c_first_event: cover property (firstEvent && s.firstIrqEnable ##1 s.firstEventFlag);
	c_set_clear: cover property (clearSecond && secondEvent);
	c_window_irq: cover property (s.windowEnable && irqRequest);
	c_adc_switch: cover property (adcEnable ##1 analogSwitch != 15'h0000);

endmodule

// *** dce_defines.svh ***
// Register indices, field positions, reset values and bus codes of the comparator event control
`ifndef DCE_DEFINES_SVH
`define DCE_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define DCE_IDX_FIRST_CTRL   3'h0
`define DCE_IDX_SECOND_CTRL  3'h1
`define DCE_IDX_ROUTE_CTRL   3'h2
`define DCE_IDX_TRIG_A       3'h3
`define DCE_IDX_TRIG_B       3'h4
`define DCE_IDX_SWITCH       3'h5
`define DCE_IDX_POLARITY     3'h6
`define DCE_IDX_LAST         3'h6

// ----------------------------------------
// Field positions of the two comparator control registers
// ----------------------------------------
`define DCE_IRQ_EN_BIT       5
`define DCE_FLAG_BIT         4
`define DCE_LEVEL_BIT        3
`define DCE_STE_BIT          2
`define DCE_SPEED_BIT        2
`define DCE_EDGE_MSB         1
`define DCE_EDGE_LSB         0

// ----------------------------------------
// Field positions of the routing control register and the trigger registers
// ----------------------------------------
`define DCE_ROUTE_MSB        7
`define DCE_ROUTE_LSB        6
`define DCE_INSEL_MSB        5
`define DCE_INSEL_LSB        3
`define DCE_REFCON_BIT       2
`define DCE_WINDOW_BIT       1
`define DCE_REFOUT_BIT       0
`define DCE_TRIG_MSB         5

// ----------------------------------------
// Edge and route codes
// ----------------------------------------
`define DCE_EDGE_OFF         2'h0
`define DCE_EDGE_FALL        2'h1
`define DCE_EDGE_RISE        2'h2
`define DCE_EDGE_BOTH        2'h3
`define DCE_ROUTE_CAP_FIRST  2'h0
`define DCE_ROUTE_CAP_SECOND 2'h1
`define DCE_ROUTE_BREAK      2'h2
`define DCE_ROUTE_REFCLR     2'h3

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define DCE_ROUTE_RESET      8'hC0
`define DCE_SWITCH_COUNT     15
`define DCE_RESP_OKAY        2'h0
`define DCE_RESP_SLVERR      2'h2

`endif

// *** dce_edge_detect.sv ***
// Synchroniser, polarity and edge detector for one comparator output
`timescale 1ns/1ns
`include "dce_defines.svh"

module dce_edge_detect (
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       rawLevel,   // Asynchronous comparator output
	input  wire logic       invert,     // Polarity of the zero crossing
	input  wire logic [1:0] edgeSelect, // Edge field of the comparator
	output logic            level,      // Synchronised, polarity-corrected level
	output logic            edgeEvent   // One-cycle pulse on the selected edge
);

	dce_pkg::dce_edge_t s;      // Current state
	dce_pkg::dce_edge_t next_s; // Next state

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// Two flops before use, then polarity, then one-cycle history
	always_comb begin
		next_s       = s;
		next_s.meta  = rawLevel;
		next_s.sync  = s.meta;
		next_s.level = s.sync ^ invert;
		next_s.last  = s.level;
	end

	// State register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Edge decode
	// ----------------------------------------
	// Rising and falling seen against the last level, gated by the edge field
	always_comb begin
		level = s.level;
		unique case (edgeSelect)
			`DCE_EDGE_FALL: edgeEvent = s.last & ~s.level;
			`DCE_EDGE_RISE: edgeEvent = s.level & ~s.last;
			`DCE_EDGE_BOTH: edgeEvent = s.level ^ s.last;
			default:        edgeEvent = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_edge_single: assert property (edgeEvent |=> !edgeEvent)
		else $error("edge event lasted more than one cycle");
	a_edge_off_quiet: assert property ((edgeSelect == `DCE_EDGE_OFF) |-> !edgeEvent)
		else $error("event raised while edge field disabled");

endmodule

// *** dce_pkg.sv ***
// Types shared by the comparator event control modules
package dce_pkg;

	// Write channel sequencing
	typedef enum logic [0:0] {WR_COLLECT, WR_RESPOND} dce_wr_state_t;

	// Read channel sequencing
	typedef enum logic [0:0] {RD_IDLE, RD_RESPOND} dce_rd_state_t;

	// State of one comparator edge detector
	typedef struct packed {
		logic meta;  // First synchroniser stage
		logic sync;  // Second synchroniser stage
		logic level; // Polarity-corrected level
		logic last;  // Level one cycle earlier
	} dce_edge_t;

	// Whole state of the control block
	typedef struct packed {
		dce_wr_state_t wrState;
		dce_rd_state_t rdState;
		logic          awReady;
		logic          wReady;
		logic [2:0]    awIdx;
		logic          awOk;
		logic [31:0]   wData;
		logic [3:0]    wStrb;
		logic          bValid;
		logic [1:0]    bResp;
		logic          arReady;
		logic          rValid;
		logic [31:0]   rData;
		logic [1:0]    rResp;
		logic          firstIrqEnable;
		logic          firstEventFlag;
		logic          schmittEnable;
		logic [1:0]    firstEdgeSelect;
		logic          secondIrqEnable;
		logic          secondEventFlag;
		logic          secondSpeedFast;
		logic [1:0]    secondEdgeSelect;
		logic [1:0]    outputRouteSelect;
		logic [2:0]    invertingInputSelect;
		logic          referenceConnect;
		logic          windowEnable;
		logic          referenceOutEnable;
		logic [5:0]    inputTrigOff;
		logic [5:0]    outputTrigOff;
		logic [14:0]   analogSwitchSet;
		logic [1:0]    polarity;
		logic [2:0]    pinMeta;
		logic [2:0]    pinSync;
		logic          irqRequest;
		logic          wakeFromWait;
		logic          wakeFromHalt;
		logic [14:0]   analogSwitch;
		logic          firstCaptureTwo;
		logic          secondCaptureTwo;
		logic          timerBreakInput;
		logic          referenceClearInput;
	} dce_ctrl_t;

endpackage

// *** tb_dce_comparator_control.sv ***
// Self-checking testbench of the comparator event control
`timescale 1ns/1ns
module tb_dce_comparator_control;
	logic        clock, sys_rst, awvalid, wvalid, bready, arvalid, rready, awready, wready;
	logic        bvalid, arready, rvalid, ultraLowPower, adcEnable, pinCaptureFirst;
	logic        pinCaptureSecond, pinBreak, irqRequest, wakeFromWait, wakeFromHalt;
	logic        firstCompRaw, secondCompRaw, wantFirst, wantSecond, timerBreakInput;
	logic        referenceClearInput, referenceConnect, windowEnable;
	logic [2:0]  invertingInputSelect;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, got;
	logic [3:0]  wstrb, adcChannel;
	logic [1:0]  bresp, rresp, resp;
	logic [14:0] analogSwitch;
	int          miscompares, compares, cycles;

	dce_comparator_control i_dut (.clock, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .firstCompRaw, .secondCompRaw, .ultraLowPower, .adcEnable, .adcChannel,
		.pinCaptureFirst, .pinCaptureSecond, .pinBreak, .irqRequest, .wakeFromWait, .wakeFromHalt,
		.referenceConnect, .windowEnable, .referenceOutEnable(), .schmittEnable(),
		.secondSpeedFast(), .invertingInputSelect, .inputTrigOff(), .outputTrigOff(),
		.analogSwitch, .firstCaptureTwo(), .secondCaptureTwo(), .timerBreakInput,
		.referenceClearInput);
	dce_analog_model i_model (.wantFirst, .wantSecond, .firstCompRaw, .secondCompRaw);

	// 50 MHz clock
	always #10 clock = ~clock;

	// Value compare
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	// Bus write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		do begin
			@(posedge clock);
			awvalid <= awvalid & ~awready;
			wvalid <= wvalid & ~wready;
		end while ((awvalid & ~awready) | (wvalid & ~wready));
		do @(posedge clock); while (!bvalid);
		resp = bresp;
	endtask

	// Bus read
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1;
		do @(posedge clock); while (!arready);
		arvalid <= 0;
		do @(posedge clock); while (!rvalid);
		got = rdata;
		resp = rresp;
	endtask

	task automatic print_verdict;
		if (miscompares == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// Hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			print_verdict();
		end
	end

	initial begin
		clock = 0;
		sys_rst <= 1;
		wstrb <= 4'hF;
		{awvalid, wvalid, arvalid, ultraLowPower, adcEnable} <= '0;
		{bready, rready} <= 2'b11; // Answers are always accepted
		{pinCaptureFirst, pinCaptureSecond, pinBreak, wantFirst, wantSecond} <= '0;
		{awaddr, araddr, wdata, adcChannel} <= '0;
		repeat (4) @(posedge clock);
		sys_rst <= 0;
		rd(8'h08);
		chk(got, 32'hC0);
		rd(8'h1C);
		chk(got, 32'h0);
		chk(resp, 32'h2);
		wr(8'h1C, 32'hFF);
		chk(resp, 32'h2);
		// Rising edge with interrupt enabled
		wr(8'h00, 32'h22);
		wantFirst <= 1;
		repeat (8) @(posedge clock);
		chk(irqRequest, 32'h1);
		chk(wakeFromHalt, 32'h1);
		rd(8'h00);
		chk(got, 32'h3A);
		// Writing zero clears; one transition sets only once
		wr(8'h00, 32'h22);
		rd(8'h00);
		chk(got, 32'h2A);
		// Falling edge with the reference stopped
		ultraLowPower <= 1;
		wr(8'h00, 32'h21);
		wantFirst <= 0;
		repeat (8) @(posedge clock);
		chk(wakeFromWait, 32'h1);
		chk(wakeFromHalt, 32'h0);
		// Mask the interrupt, keep the flag
		wr(8'h00, 32'h11);
		repeat (2) @(posedge clock);
		chk(irqRequest, 32'h0);
		rd(8'h00);
		chk(got, 32'h11);
		// Second output routed to the break input
		wr(8'h08, 32'h80);
		wantSecond <= 1;
		repeat (8) @(posedge clock);
		chk(timerBreakInput, 32'h1);
		chk(referenceClearInput, 32'h0);
		// Outside window: reference, threshold, window bit, shared input, edges
		ultraLowPower <= 0;
		wr(8'h08, 32'h84);
		wr(8'h08, 32'hAC);
		wr(8'h08, 32'hAE);
		wr(8'h14, 32'h4000);
		wr(8'h00, 32'h22);
		wr(8'h04, 32'h21);
		chk(analogSwitch, 32'h4000);
		chk({referenceConnect, windowEnable, invertingInputSelect}, 32'h1D);
		wantSecond <= 0;
		repeat (8) @(posedge clock);
		chk(irqRequest, 32'h1);
		chk(wakeFromHalt, 32'h1);
		chk(timerBreakInput, 32'h0);
		rd(8'h04);
		chk(got, 32'h31);
		// Fixed comparator off before the ADC takes the switches
		wr(8'h00, 32'h10);
		// ADC owns the switches
		adcEnable <= 1;
		adcChannel <= 4'h3;
		repeat (2) @(posedge clock);
		chk(analogSwitch, 32'h8);
		print_verdict();
	end
endmodule
